/* logic/ext_interrupt_priority_unit.v */
// Purpose: Interrupt priority register, external line configuration and priority arbitration.
// Assumes: Core drives sfr_* byte/bit accesses; one access per cycle; core pulses ack and reti.
// Notes: Unused priority bit reads as one; bit writes use sfr_bit_en with sfr_bit_sel.
`timescale 1ns/1ns
`include "ext_int_map.vh"
// Behaviour
// (RULE1) Priority bit 7 always reads one; writes to it are ignored.
// (RULE2) Priority bit 6 sets serial peripheral interrupt low or high.
// (RULE3) Priority bit 5 sets timer C interrupt low or high.
// (RULE4) Priority bit 4 sets asynchronous serial interrupt low or high.
// (RULE5) Priority bit 3 sets timer B interrupt low or high.
// (RULE6) Priority bit 2 sets external line B low or high.
// (RULE7) Priority bit 1 sets timer A interrupt low or high.
// (RULE8) Priority bit 0 sets external line A low or high.
// (RULE9) Priority register at 0xB8, also reachable by single-bit access.
// (RULE10) Polarity bit per line: zero active low, one active high.
// (RULE11) Trigger bit per line: one edge, zero level detection.
// (RULE12) Lines sample their selected pin without disturbing its owner.
// (RULE13) Line A and B pending flags are timer control bits 1 and 3.
// (RULE14) Edge mode pending flag clears when the core vectors there.
// (RULE15) Level mode pending flag follows the active input level.
// (RULE16) Level requester holds input until request is recognised.
// (RULE17) Level requester releases before routine ends, else another request.
// (RULE18) High priority preempts low; low never preempts high.
module ext_interrupt_priority_unit #(
  parameter PINS = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire sfr_bit_en,
  input wire [2:0] sfr_bit_sel,
  input wire [PINS-1:0] port_pins,
  input wire [`SRC_COUNT-1:0] periph_req,
  input wire int_ack,
  input wire int_reti,
  output reg [7:0] sfr_rdata,
  output reg int_req,
  output reg [2:0] int_src,
  output reg int_high
);
  reg [7:0] prio_reg;
  reg [7:0] cfg_reg;
  reg a_trig_reg;
  reg b_trig_reg;
  reg in_low_reg;
  reg in_high_reg;
  reg [7:0] rdata_next;
  reg [2:0] pick_src;
  reg pick_valid;
  reg pick_high;
  integer i;
  wire pend_a;
  wire pend_b;
  wire prio_hit;
  wire cfg_hit;
  wire tctl_hit;
  wire [7:0] prio_view;
  wire [7:0] tctl_view;
  wire [`SRC_COUNT-1:0] req_vec;
  wire ack_a;
  wire ack_b;

  // Merge a bit-instruction write into the current byte.
  function [7:0] merge;
    input [7:0] cur;
    input [7:0] wdata;
    input bit_en;
    input [2:0] sel;
    begin
      merge = cur;
      if (bit_en)
        merge[sel] = wdata[0];
      else
        merge = wdata;
    end
  endfunction

  assign prio_hit = (sfr_addr == `PRIO_ADDR); // RULE9
  assign cfg_hit = (sfr_addr == `CFG_ADDR);
  assign tctl_hit = (sfr_addr == `TCTL_ADDR);
  assign prio_view = {1'b1, prio_reg[6:0]}; // RULE1
  assign tctl_view = {4'h0, pend_b, b_trig_reg, pend_a, a_trig_reg}; // RULE13
  assign req_vec = {periph_req[6:3], pend_b, periph_req[1], pend_a};
  assign ack_a = int_ack && int_src == `SRC_EXT_A;
  assign ack_b = int_ack && int_src == `SRC_EXT_B;

  ext_line_detect #(.PINS(PINS)) line_a (
    .clk(clk),
    .sys_rst(sys_rst),
    .port_pins(port_pins),
    .pin_sel(cfg_reg[`CFG_A_PIN_LSB+2:`CFG_A_PIN_LSB]),
    .polarity(cfg_reg[`CFG_A_POL_BIT]),
    .edge_mode(a_trig_reg),
    .vector_ack(ack_a),
    .pend_wr(sfr_wr && tctl_hit && (!sfr_bit_en || sfr_bit_sel == `TCTL_A_PEND_BIT)),
    .pend_wdata(sfr_bit_en ? sfr_wdata[0] : sfr_wdata[`TCTL_A_PEND_BIT]),
    .pending(pend_a)
  );

  ext_line_detect #(.PINS(PINS)) line_b (
    .clk(clk),
    .sys_rst(sys_rst),
    .port_pins(port_pins),
    .pin_sel(cfg_reg[`CFG_B_PIN_LSB+2:`CFG_B_PIN_LSB]),
    .polarity(cfg_reg[`CFG_B_POL_BIT]),
    .edge_mode(b_trig_reg),
    .vector_ack(ack_b),
    .pend_wr(sfr_wr && tctl_hit && (!sfr_bit_en || sfr_bit_sel == `TCTL_B_PEND_BIT)),
    .pend_wdata(sfr_bit_en ? sfr_wdata[0] : sfr_wdata[`TCTL_B_PEND_BIT]),
    .pending(pend_b)
  );

  // Lowest index wins within a level; a high request beats any low one.
  always @* begin
    pick_src = 3'h0;
    pick_valid = 1'b0;
    pick_high = 1'b0;
    for (i = `SRC_COUNT - 1; i >= 0; i = i - 1) begin
      if (req_vec[i] && prio_reg[i]) begin // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8
        pick_src = i[2:0];
        pick_valid = 1'b1;
        pick_high = 1'b1;
      end
    end
    if (!pick_valid) begin
      for (i = `SRC_COUNT - 1; i >= 0; i = i - 1) begin
        if (req_vec[i]) begin
          pick_src = i[2:0];
          pick_valid = 1'b1;
        end
      end
    end
    // Nothing preempts a high routine; only high preempts a low one.
    if (in_high_reg || (in_low_reg && !pick_high))
      pick_valid = 1'b0; // RULE18
  end

  always @* begin
    rdata_next = 8'h00;
    if (prio_hit)
      rdata_next = prio_view;
    else if (cfg_hit)
      rdata_next = cfg_reg;
    else if (tctl_hit)
      rdata_next = tctl_view;
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      prio_reg <= `PRIO_RESET;
      cfg_reg <= `CFG_RESET;
      a_trig_reg <= 1'b0;
      b_trig_reg <= 1'b0;
      in_low_reg <= 1'b0;
      in_high_reg <= 1'b0;
      sfr_rdata <= 8'h00;
      int_req <= 1'b0;
      int_src <= 3'h0;
      int_high <= 1'b0;
    end else begin
      if (sfr_wr && prio_hit) begin
        prio_reg <= merge(prio_reg, sfr_wdata, sfr_bit_en, sfr_bit_sel);
        prio_reg[`PRIO_FIXED_BIT] <= 1'b1; // RULE1
      end
      if (sfr_wr && cfg_hit)
        cfg_reg <= merge(cfg_reg, sfr_wdata, sfr_bit_en, sfr_bit_sel);
      if (sfr_wr && tctl_hit) begin
        if (!sfr_bit_en || sfr_bit_sel == `TCTL_A_TRIG_BIT)
          a_trig_reg <= sfr_bit_en ? sfr_wdata[0] : sfr_wdata[`TCTL_A_TRIG_BIT]; // RULE11
        if (!sfr_bit_en || sfr_bit_sel == `TCTL_B_TRIG_BIT)
          b_trig_reg <= sfr_bit_en ? sfr_wdata[0] : sfr_wdata[`TCTL_B_TRIG_BIT];
      end
      if (sfr_rd)
        sfr_rdata <= rdata_next;
      // Nesting depth: entering records the level, return unwinds the innermost.
      if (int_ack && int_req) begin
        if (int_high)
          in_high_reg <= 1'b1;
        else
          in_low_reg <= 1'b1;
      end else if (int_reti) begin
        if (in_high_reg)
          in_high_reg <= 1'b0;
        else
          in_low_reg <= 1'b0;
      end
      // Request drops the cycle after acknowledge so the flag clear is seen.
      int_req <= pick_valid && !int_ack;
      int_src <= pick_src;
      int_high <= pick_high;
    end
  end
endmodule

/* include/ext_int_map.vh */
// Purpose: Addresses, field positions, reset values and counts for the external interrupt priority unit.
// Assumes: 8-bit special-function bus with byte and bit access.
// Notes: Configuration and timer-control addresses are local choices.
`ifndef EXT_INT_MAP_VH
`define EXT_INT_MAP_VH
`define PRIO_ADDR 8'hB8
`define PRIO_RESET 8'h80
`define PRIO_FIXED_BIT 7
`define CFG_ADDR 8'hE4
`define CFG_RESET 8'h01
`define CFG_A_POL_BIT 3
`define CFG_B_POL_BIT 7
`define CFG_A_PIN_LSB 0
`define CFG_B_PIN_LSB 4
`define TCTL_ADDR 8'h88
`define TCTL_A_TRIG_BIT 0
`define TCTL_A_PEND_BIT 1
`define TCTL_B_TRIG_BIT 2
`define TCTL_B_PEND_BIT 3
`define SRC_COUNT 7
`define SRC_EXT_A 0
`define SRC_EXT_B 2
`define SYNC_STAGES 3
`endif

/* logic/ext_line_detect.v */
// Purpose: One external interrupt line: pin select, synchroniser, polarity, edge or level pending flag.
// Assumes: Pins are asynchronous to clk.
// Notes: The pin bus is only observed, never driven.
`timescale 1ns/1ns
`include "ext_int_map.vh"
module ext_line_detect #(
  parameter PINS = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire [PINS-1:0] port_pins,
  input wire [2:0] pin_sel,
  input wire polarity,
  input wire edge_mode,
  input wire vector_ack,
  input wire pend_wr,
  input wire pend_wdata,
  output wire pending
);
  reg [2:0] sync_reg;
  reg pend_reg;
  reg pend_next;
  reg active_prev_reg;
  wire raw_pin;
  wire settled;
  wire active;
  // Sampling taps the pad regardless of which peripheral owns it.
  assign raw_pin = port_pins[pin_sel]; // RULE12
  assign settled = sync_reg[2];
  // Active level only once stages two and three agree.
  assign active = ((sync_reg[1] == sync_reg[2]) ? settled : active_prev_reg ^ ~polarity) ^ ~polarity; // RULE10
  always @* begin
    pend_next = pend_reg;
    if (edge_mode) begin // RULE11
      if (pend_wr)
        pend_next = pend_wdata;
      if (vector_ack)
        pend_next = 1'b0; // RULE14
      if (active && !active_prev_reg)
        pend_next = 1'b1;
    end else begin
      pend_next = active; // RULE15
    end
  end
  always @(posedge clk) begin
    if (sys_rst) begin
      // Start at the inactive pad level so release of reset is not taken as a request.
      sync_reg <= {3{~polarity}};
      pend_reg <= 1'b0;
      active_prev_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], raw_pin};
      pend_reg <= pend_next;
      active_prev_reg <= active;
    end
  end
  assign pending = pend_reg;
endmodule

/* test/ext_int_checker_properties.sv */
// Purpose: Port-level properties of the external interrupt priority unit.
// Assumes: One clock, synchronous active-high reset.
// Notes: Ports are grouped on few lines to keep the checker short.
`timescale 1ns/1ns
`include "ext_int_map.vh"
module ext_int_checker #(
  parameter PINS = 8
) (
  input logic clk, sys_rst, sfr_wr, sfr_rd, sfr_bit_en, int_ack, int_reti, int_req, int_high,
  input logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
  input logic [2:0] sfr_bit_sel, int_src,
  input logic [PINS-1:0] port_pins,
  input logic [`SRC_COUNT-1:0] periph_req
);
  wire wbit = sfr_wdata[0];
  wire prio_rd = sfr_rd && sfr_addr == 8'hB8;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  fixed_bit_a: assert property (prio_rd |=> sfr_rdata[7]) else $error("priority bit 7 read as zero");
  byte_write_a: assert property (sfr_wr && !sfr_bit_en && sfr_addr == 8'hB8 ##1 prio_rd
    |=> sfr_rdata == ($past(sfr_wdata, 2) | 8'h80)) else $error("priority byte write lost");
  bit_write_a: assert property (sfr_wr && sfr_bit_en && sfr_addr == 8'hB8 ##1 prio_rd
    |=> sfr_rdata[$past(sfr_bit_sel, 2)] == ($past(wbit, 2) || $past(sfr_bit_sel, 2) == 3'h7))
    else $error("priority bit write lost");
  tctl_upper_a: assert property (sfr_rd && sfr_addr == 8'h88 |=> sfr_rdata[7:4] == 4'h0)
    else $error("timer control upper bits not zero");
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
  ack_drop_a: assert property (int_ack |=> !int_req) else $error("request stayed after ack");
  high_block_a: assert property (int_ack && int_high ##1 !int_reti [*2] |=> !int_req)
    else $error("request inside high routine");
  unmapped_a: assert property (sfr_rd && sfr_addr != 8'hB8 && sfr_addr != 8'hE4 && sfr_addr != 8'h88
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind ext_interrupt_priority_unit ext_int_checker #(.PINS(PINS)) chk_i (.*);

/* test/ext_requester.sv */
// Purpose: External requester on one port pin, active low.
// Assumes: Idle pads rest at their pull-up level.
// Notes: Holds its request until any vector acknowledge.
`timescale 1ns/1ns
module ext_requester #(
  parameter PIN = 1
) (
  input wire logic clk,
  input wire logic start,
  input wire logic int_ack,
  output logic [7:0] port_pins
);
  logic req_reg = 1'b0;
  assign port_pins = ~({7'h00, req_reg} << PIN);
  always @(posedge clk) begin
    if (start)
      req_reg <= 1'b1;
    else if (int_ack)
      req_reg <= 1'b0;
  end
endmodule

/* test/tb_top.sv */
// Purpose: Self-checking bench for the external interrupt priority unit.
// Assumes: Tasks start off the edge or right after one.
// Notes: Line A uses pin 1, active low, as after reset.
`timescale 1ns/1ns
module tb_top;
  logic clk = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, sfr_bit_en = 0, int_ack = 0, int_reti = 0, start = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, pins;
  logic [2:0] sfr_bit_sel = 3'h0, int_src;
  logic [6:0] periph_req = 7'h00;
  logic int_req, int_high;
  int error_cnt = 0, comparisons = 0;
  always #2 clk = ~clk;
  ext_interrupt_priority_unit dut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_bit_en(sfr_bit_en), .sfr_bit_sel(sfr_bit_sel),
    .port_pins(pins), .periph_req(periph_req), .int_ack(int_ack), .int_reti(int_reti),
    .sfr_rdata(sfr_rdata), .int_req(int_req), .int_src(int_src), .int_high(int_high));
  ext_requester req (.clk(clk), .start(start), .int_ack(int_ack), .port_pins(pins));
  task chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, d, input logic b, input logic [2:0] s);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_bit_en <= b;
    sfr_bit_sel <= s;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_bit_en <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, exp);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 chk(sfr_rdata, exp);
  endtask
  task wait_req(input logic h, input logic [2:0] s);
    repeat (20) begin
      @(posedge clk);
      #1;
      if (int_req === 1'b1)
        break;
    end
    chk({3'h0, int_req, int_high, int_src}, {3'h0, 1'b1, h, s});
  endtask
  task pulse(input int which);
    if (which == 0) int_ack <= 1'b1; else if (which == 1) int_reti <= 1'b1; else start <= 1'b1;
    @(posedge clk);
    int_ack <= 1'b0;
    int_reti <= 1'b0;
    start <= 1'b0;
    #1;
    if (which == 0) chk({7'h00, int_req}, 8'h00);
  endtask
  task t_regs;
    rd(8'hB8, 8'h80);
    rd(8'hE4, 8'h01);
    rd(8'h88, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(8'hB8, 8'h01 << i, 1'b0, 3'h0);
      rd(8'hB8, 8'h80 | (8'h01 << i));
    end
    wr(8'hB8, 8'h00, 1'b1, 3'h7);
    rd(8'hB8, 8'hC0);
    wr(8'hB8, 8'h01, 1'b1, 3'h2);
    rd(8'hB8, 8'hC4);
    wr(8'h55, 8'hFF, 1'b0, 3'h0);
    rd(8'h55, 8'h00);
  endtask
  task t_level;
    wr(8'hB8, 8'h00, 1'b0, 3'h0);
    pulse(2);
    wait_req(1'b0, 3'h0);
    rd(8'h88, 8'h02);
    pulse(0);
    repeat (8) @(posedge clk);
    rd(8'h88, 8'h00);
    pulse(1);
  endtask
  task t_edge;
    wr(8'h88, 8'h01, 1'b0, 3'h0);
    pulse(2);
    wait_req(1'b0, 3'h0);
    rd(8'h88, 8'h03);
    pulse(0);
    rd(8'h88, 8'h01);
    pulse(1);
  endtask
  task t_line_b;
    wr(8'hB8, 8'h04, 1'b0, 3'h0);
    wr(8'hE4, 8'h81, 1'b0, 3'h0);
    wait_req(1'b1, 3'h2);
    rd(8'h88, 8'h09);
    pulse(0);
    wr(8'hE4, 8'h01, 1'b0, 3'h0);
    repeat (2) @(posedge clk);
    rd(8'h88, 8'h01);
    pulse(1);
  endtask
  task t_prio;
    wr(8'h88, 8'h00, 1'b0, 3'h0);
    wr(8'hB8, 8'h08, 1'b0, 3'h0);
    periph_req <= 7'h0A;
    wait_req(1'b1, 3'h3);
    pulse(0);
    periph_req <= 7'h02;
    repeat (4) @(posedge clk);
    #1 chk({7'h00, int_req}, 8'h00);
    pulse(1);
    wait_req(1'b0, 3'h1);
    pulse(0);
    periph_req <= 7'h00;
    pulse(1);
  endtask
  task report_and_stop;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_level;
    t_edge;
    t_line_b;
    t_prio;
    report_and_stop;
  end
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    report_and_stop;
  end
endmodule
